// *** tb.sv ***
// Testbench of the watchdog against a small register model
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int BASE = 4;
   localparam int DIV = 2;
   logic mclk, rst_n, wr_en, rd_en, kick_instruction, chip_reset, always_on_fuse;
   logic wdt_reset, irq;
   logic [3:0] addr;
   logic [7:0] wr_data, rd_data;
   int cyc, wt, m_en, m_p, m_flag, m_stat, m_mask, n_rst, k;
   int miscompares, n_compared;
   int seed = 20603;
   wdg_top #(.BASE_TIMEOUT(BASE), .OSC_DIV(DIV)) wdg_top_i (.mclk(mclk), .rst_n(rst_n),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .kick_instruction(kick_instruction), .chip_reset(chip_reset),
      .always_on_fuse(always_on_fuse), .wdt_reset(wdt_reset), .irq(irq));
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      n_rst <= n_rst + int'(wdt_reset === 1'b1);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic mclr;
      m_en = 0;
      m_p = 0;
      wt = -100;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
      if (a == 4'h1 && !d[0])
         m_flag = 0;
      if (a == 4'h3)
         m_mask = d[1:0];
      if (a != 4'h0)
         return;
      if (cyc - wt <= 4)
      begin
         m_en = d[3];
         m_p = d[2:0];
      end
      else
      begin
         m_stat |= (!d[3] && m_en || d[2:0] != m_p) ? 2 : 0;
         m_en |= d[3];
      end
      wt = d[4] ? cyc : -100;
   endtask
   task automatic rdc(input logic [3:0] a);
      int e;
      @(posedge mclk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      e = a == 4'h0 ? 16 * int'(cyc - wt <= 4) + 8 * int'(m_en || always_on_fuse) + m_p
         : a == 4'h1 ? m_flag : a == 4'h2 ? m_stat : a == 4'h3 ? m_mask : 0;
      if (a == 4'h2)
         m_stat = 0;
      #1;
      chk(rd_data, e);
   endtask
   task automatic kick;
      @(posedge mclk);
      kick_instruction <= 1'b1;
      @(posedge mclk);
      kick_instruction <= 1'b0;
   endtask
   // Tick phase is unknown, so the measured span gets a little slack on top
   task automatic tmo(input int p);
      int n;
      int e;
      kick();
      n = 0;
      e = (BASE << p) * DIV;
      while (wdt_reset !== 1'b1 && n < 5000)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk((n >= e && n <= e + DIV + 4) ? e : n, e);
      mclr();
      m_flag = 1;
      m_stat |= 1;
   endtask
   initial
   begin
      #1000000;
      miscompares++;
      give_verdict();
   end
   initial
   begin
      {rst_n, wr_en, rd_en, kick_instruction, chip_reset, always_on_fuse} = 6'h00;
      addr = 4'h0;
      wr_data = 8'h00;
      mclr();
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      wr(4'h8 | 4'($random(seed)), 8'($random(seed)));
      for (k = 0; k < 8; k++)
         rdc(4'(k));
      wr(4'h3, 8'h03);
      wr(4'h0, 8'h18);
      rdc(4'h0);
      wr(4'h0, 8'h0f);
      wr(4'h0, 8'h07);
      wr(4'h0, 8'h0b);
      rdc(4'h0);
      chk(irq, (m_stat & m_mask) != 0);
      rdc(4'h2);
      wr(4'h0, 8'h1f);
      repeat (3) @(posedge mclk);
      wr(4'h0, 8'h07);
      wr(4'h0, 8'h1f);
      wr(4'h0, 8'h07);
      rdc(4'h0);
      rdc(4'h2);
      for (k = 0; k < 8; k++)
      begin
         wr(4'h0, 8'h18);
         wr(4'h0, 8'h08 | 8'(k));
         tmo(k);
         rdc(4'h1);
         rdc(4'h2);
         rdc(4'h0);
      end
      wr(4'h1, 8'h01);
      rdc(4'h1);
      wr(4'h1, 8'h00);
      rdc(4'h1);
      wr(4'h0, 8'h18);
      k = n_rst;
      repeat (12)
      begin
         repeat (1 + ($random(seed) & 1)) @(posedge mclk);
         kick();
      end
      @(posedge mclk);
      chip_reset <= 1'b1;
      @(posedge mclk);
      chip_reset <= 1'b0;
      mclr();
      repeat (40) @(posedge mclk);
      chk(n_rst, k);
      rdc(4'h0);
      wr(4'h0, 8'h1f);
      wr(4'h0, 8'h07);
      always_on_fuse <= 1'b1;
      repeat (4) @(posedge mclk);
      rdc(4'h0);
      wr(4'h0, 8'h1f);
      wr(4'h0, 8'h01);
      tmo(1);
      @(posedge mclk);
      always_on_fuse <= 1'b0;
      rst_n <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      m_flag = 0;
      m_stat = 0;
      m_mask = 0;
      rdc(4'h1);
      give_verdict();
   end
endmodule
`default_nettype wire

// *** wdg_asserts.sv ***
// Port-level assertions of the watchdog
`timescale 1ns/10ps
`default_nettype none
module wdg_asserts #(
   parameter int BASE_TIMEOUT = 4,
   parameter int OSC_DIV = 2
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] rd_data,
   input wire logic kick_instruction,
   input wire logic chip_reset,
   input wire logic always_on_fuse,
   input wire logic wdt_reset,
   input wire logic irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_pulse_one: assert property (wdt_reset |=> !wdt_reset)
      else $error("reset pulse too long");
   a_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
      else $error("read data outside read");
   a_rsv_zero: assert property (rd_en && addr == 4'h0 |=> rd_data[7:5] == 3'h0)
      else $error("reserved bits set");
   a_unmapped_zero: assert property (rd_en && addr > 4'h3 |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_fuse_en: assert property (always_on_fuse[*4] ##0 rd_en && addr == 4'h0 |=> rd_data[3])
      else $error("enable low with fuse");
   a_kick_quiet: assert property (kick_instruction |-> ##3 !wdt_reset[*4])
      else $error("timeout right after kick");
   a_chip_quiet: assert property (chip_reset |-> ##3 !wdt_reset[*4])
      else $error("timeout right after chip reset");
   // Read clears status, so irq must drop unless a new event lands
   a_irq_clear: assert property (rd_en && addr == 4'h2 && !wdt_reset ##1
      !wr_en && !wdt_reset ##1 !wdt_reset |-> !irq)
      else $error("irq stays after status read");
endmodule
bind wdg_top wdg_asserts #(.BASE_TIMEOUT(BASE_TIMEOUT), .OSC_DIV(OSC_DIV)) wdg_asserts_i (
   .mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
   .rd_en(rd_en), .rd_data(rd_data), .kick_instruction(kick_instruction),
   .chip_reset(chip_reset), .always_on_fuse(always_on_fuse), .wdt_reset(wdt_reset),
   .irq(irq));
`default_nettype wire

// *** wdg_count.sv ***
// Watchdog timeout counter stepped by the oscillator tick
`timescale 1ns/10ps
`default_nettype none
module wdg_count #(
   parameter int CW = 22,
   parameter int BASE = wdg_pkg::BASE_TIMEOUT
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic clear,
   input wire logic run,
   input wire logic [2:0] period_sel,
   output logic expire
);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic next_expire;
   logic [CW-1:0] limit;

   initial
   begin
      if ((BASE < 2) || (64'(BASE) * 128 > (64'd1 << CW)))
         $error("wdg_count: BASE does not fit the counter");
   end

   always_comb
   begin
      limit = CW'(BASE) << period_sel;
      next_count = count;
      next_expire = 1'b0;
      if (clear || !run)
         next_count = '0;
      else if (tick)
      begin
         // Compare with >= so a shortened period cannot skip past the limit
         if (count >= limit - CW'(1))
         begin
            next_expire = 1'b1;
            next_count = '0;
         end
         else
            next_count = count + CW'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= '0;
         expire <= 1'b0;
      end
      else
      begin
         count <= next_count;
         expire <= next_expire;
      end
   end
endmodule
`default_nettype wire

// *** wdg_pkg.sv ***
// Package with register map, field layout, reset values and timing counts of the watchdog
package wdg_pkg;
   // ******************************
   // Register map
   // ******************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_FLAG = 4'h1;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
   // ******************************
   // Control field layout
   // ******************************
   localparam int CHANGE_UNLOCK_POS = 4;
   localparam int DOG_ENABLE_POS = 3;
   localparam int PERIOD_LSB = 0;
   localparam int PERIOD_W = 3;
   localparam logic [2:0] RESERVED_BITS = 3'h0;
   localparam logic [2:0] PERIOD_RESET = 3'h0;
   localparam logic DOG_ENABLE_RESET = 1'b0;
   // ******************************
   // Flag and interrupt layout
   // ******************************
   localparam int DOG_RESET_FLAG_POS = 0;
   localparam int IRQ_W = 2;
   localparam int IRQ_TIMEOUT_POS = 0;
   localparam int IRQ_REFUSED_POS = 1;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   // ******************************
   // Timing
   // ******************************
   localparam int SYS_CLK_HZ = 40000000;
   localparam int OSC_HZ = 1000000;
   localparam int OSC_DIV = SYS_CLK_HZ / OSC_HZ;
   localparam int UNLOCK_CYCLES = 4;
   localparam int BASE_TIMEOUT = 16384;
endpackage

// *** wdg_sync.sv ***
// Two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module wdg_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_sync_out;

   always_comb
   begin
      next_stage1 = async_in;
      next_sync_out = stage1;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1 <= next_stage1;
         sync_out <= next_sync_out;
      end
   end
endmodule
`default_nettype wire

// *** wdg_top.sv ***
// Watchdog timer with timed unlock sequence, register port and interrupt
`timescale 1ns/10ps
`default_nettype none
module wdg_top #(
   parameter int BASE_TIMEOUT = wdg_pkg::BASE_TIMEOUT,
   parameter int OSC_DIV = wdg_pkg::OSC_DIV
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   input wire logic kick_instruction,
   input wire logic chip_reset,
   input wire logic always_on_fuse,
   output logic wdt_reset,
   output logic irq
);
   // ******************************
   // Oscillator tick
   // ******************************
   localparam int DW = $clog2(OSC_DIV + 1);
   logic [DW-1:0] div_cnt;
   logic [DW-1:0] next_div_cnt;
   logic osc_tick;
   logic next_osc_tick;

   initial
   begin
      if (OSC_DIV < 1)
         $error("wdg_top: OSC_DIV must be at least one");
   end

   // The oscillator is modelled as an enable pulse, so no clock crossing is needed
   always_comb
   begin
      next_osc_tick = 1'b0;
      next_div_cnt = div_cnt + DW'(1);
      if (div_cnt >= DW'(OSC_DIV - 1))
      begin
         next_div_cnt = '0;
         next_osc_tick = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt <= '0;
         osc_tick <= 1'b0;
      end
      else
      begin
         div_cnt <= next_div_cnt;
         osc_tick <= next_osc_tick;
      end
   end

   // ******************************
   // Fuse pin and counter
   // ******************************
   logic fuse_on;
   logic expire;
   logic dog_enable_bit;
   logic [2:0] period_sel;
   logic count_clear;
   logic dog_run;

   wdg_sync #(.W(1)) u_fuse_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in(always_on_fuse),
      .sync_out(fuse_on)
   );

   assign dog_run = dog_enable_bit || fuse_on;
   assign count_clear = kick_instruction || chip_reset || wdt_reset;

   wdg_count #(.CW(22), .BASE(BASE_TIMEOUT)) u_count (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(osc_tick),
      .clear(count_clear),
      .run(dog_run),
      .period_sel(period_sel),
      .expire(expire)
   );

   // ******************************
   // Registers
   // ******************************
   logic [2:0] unlock_cnt;
   logic [2:0] next_unlock_cnt;
   logic next_dog_enable_bit;
   logic [2:0] next_period_sel;
   logic dog_reset_flag;
   logic next_dog_reset_flag;
   logic [1:0] irq_stat;
   logic [1:0] next_irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] next_irq_mask;
   logic [7:0] next_rd_data;
   logic next_wdt_reset;
   logic next_irq;
   logic change_unlock_bit;
   logic [1:0] ev;
   logic w_unlock;
   logic w_enable;
   logic [2:0] w_period;

   // One place decides whether a strobe hits a register, so reads and writes agree
   function automatic logic reg_hit(
      input logic strobe,
      input logic [3:0] a,
      input logic [3:0] target
   );
      reg_hit = strobe && (a == target);
   endfunction

   assign change_unlock_bit = (unlock_cnt != 3'h0);
   assign w_unlock = wr_data[wdg_pkg::CHANGE_UNLOCK_POS];
   assign w_enable = wr_data[wdg_pkg::DOG_ENABLE_POS];
   assign w_period = wr_data[wdg_pkg::PERIOD_LSB +: wdg_pkg::PERIOD_W];

   always_comb
   begin
      next_unlock_cnt = unlock_cnt;
      next_dog_enable_bit = dog_enable_bit;
      next_period_sel = period_sel;
      next_dog_reset_flag = dog_reset_flag;
      next_irq_mask = irq_mask;
      ev = 2'h0;
      if (change_unlock_bit)
         next_unlock_cnt = unlock_cnt - 3'h1;
      if (reg_hit(wr_en, addr, wdg_pkg::ADDR_CTRL))
      begin
         if (change_unlock_bit)
         begin
            next_period_sel = w_period;
            next_dog_enable_bit = w_enable;
         end
         else
         begin
            if (w_enable)
               next_dog_enable_bit = 1'b1;
            else if (dog_enable_bit)
               ev[wdg_pkg::IRQ_REFUSED_POS] = 1'b1;
            if (w_period != period_sel)
               ev[wdg_pkg::IRQ_REFUSED_POS] = 1'b1;
         end
         // Any write of the unlock bit opens a fresh window; a zero write closes it
         if (w_unlock)
            next_unlock_cnt = 3'(wdg_pkg::UNLOCK_CYCLES);
         else
            next_unlock_cnt = 3'h0;
      end
      if (reg_hit(wr_en, addr, wdg_pkg::ADDR_FLAG) && !wr_data[wdg_pkg::DOG_RESET_FLAG_POS])
         next_dog_reset_flag = 1'b0;
      if (reg_hit(wr_en, addr, wdg_pkg::ADDR_IRQ_MASK))
         next_irq_mask = wr_data[wdg_pkg::IRQ_W-1:0];
      if (expire)
      begin
         ev[wdg_pkg::IRQ_TIMEOUT_POS] = 1'b1;
         next_dog_reset_flag = 1'b1;
      end
      // Chip reset returns control to its reset values; the flag survives it
      if (chip_reset || wdt_reset)
      begin
         next_unlock_cnt = 3'h0;
         next_dog_enable_bit = wdg_pkg::DOG_ENABLE_RESET;
         next_period_sel = wdg_pkg::PERIOD_RESET;
      end
      // A read clears the status, but an event in the same cycle still lands
      next_irq_stat = irq_stat;
      if (reg_hit(rd_en, addr, wdg_pkg::ADDR_IRQ_STAT))
         next_irq_stat = 2'h0;
      next_irq_stat = next_irq_stat | ev;
      next_irq = |(next_irq_stat & next_irq_mask);
      next_wdt_reset = expire;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         unlock_cnt <= 3'h0;
         dog_enable_bit <= wdg_pkg::DOG_ENABLE_RESET;
         period_sel <= wdg_pkg::PERIOD_RESET;
         dog_reset_flag <= 1'b0;
         irq_stat <= 2'h0;
         irq_mask <= wdg_pkg::IRQ_MASK_RESET;
         wdt_reset <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         unlock_cnt <= next_unlock_cnt;
         dog_enable_bit <= next_dog_enable_bit;
         period_sel <= next_period_sel;
         dog_reset_flag <= next_dog_reset_flag;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         wdt_reset <= next_wdt_reset;
         irq <= next_irq;
      end
   end

   // ******************************
   // Read port
   // ******************************
   // Data stand for one cycle only, then fall back to zero
   always_comb
   begin
      next_rd_data = 8'h00;
      if (rd_en)
      begin
         case (addr)
            wdg_pkg::ADDR_CTRL:
               next_rd_data = {wdg_pkg::RESERVED_BITS, change_unlock_bit, dog_run,
                               period_sel};
            wdg_pkg::ADDR_FLAG:
               next_rd_data = {7'h00, dog_reset_flag};
            wdg_pkg::ADDR_IRQ_STAT:
               next_rd_data = {6'h00, irq_stat};
            wdg_pkg::ADDR_IRQ_MASK:
               next_rd_data = {6'h00, irq_mask};
            default:
               next_rd_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= 8'h00;
      else
         rd_data <= next_rd_data;
   end
endmodule
`default_nettype wire
